// ---- common/irq_link_if.sv ----
// link between interrupt controller and core dispatch end
// assumes both ends on the same clock
`timescale 1ns/1ps
interface irq_link_if;
   logic       irq_req; // a pending, unmasked request exists
   logic [7:0] irq_vec; // vector of highest pending request
   logic       irq_ack; // one-cycle acknowledge from the core
   modport ctrl (output irq_req, output irq_vec, input irq_ack);
   modport core (input irq_req, input irq_vec, output irq_ack);
endinterface : irq_link_if

// ---- common/irq_pkg.sv ----
// constants shared by the interrupt controller and the core dispatch end
// assumes one clock domain and 8-bit register space
package irq_pkg;
   // register offsets in the core register space
   localparam logic [7:0] CLR_LOW_OFS  = 8'hDA;
   localparam logic [7:0] CLR_MID_OFS  = 8'hDB;
   localparam logic [7:0] CLR_HIGH_OFS = 8'hDC;
   localparam logic [7:0] SOFT_CTL_OFS = 8'hDE;
   localparam logic [7:0] MASK_HI_OFS  = 8'hDF;
   localparam logic [7:0] MASK_LO_OFS  = 8'hE0;
   localparam logic [7:0] MASK_MID_OFS = 8'hE1;
   // reset values
   localparam logic [7:0]  REG_RST     = 8'h00;
   localparam logic [23:0] POSTED_RST  = 24'h000000;
   // soft_irq_enable position in irq_soft_control
   localparam int          SOFT_EN_BIT = 7;
   // reserved bit 7 of irq_posted_clear_high
   localparam logic [23:0] VIEW_USED   = 24'h7FFFFF;
   // number of real sources
   localparam int          NSRC        = 23;
   // view bit of each source, in priority order
   localparam logic [4:0] PRIO_POS [NSRC] = '{
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h07, 5'h05, 5'h08,
      5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10,
      5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h06};
   // priority number of each entry above
   localparam logic [4:0] PRIO_NUM [NSRC] = '{
      5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
      5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10,
      5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h19};
   // vectors are four bytes apart
   localparam int          VEC_SHIFT   = 2;
   // dispatch timing, counted from the start cycle
   localparam logic [3:0]  DISP_LAST   = 4'hC;
   localparam logic [3:0]  STEP_PCH    = 4'h0;
   localparam logic [3:0]  STEP_PCL    = 4'h1;
   localparam logic [3:0]  STEP_FLAGS  = 4'h2;
   localparam logic [3:0]  STEP_FCLR   = 4'h3;
   localparam logic [3:0]  STEP_ACK    = 4'h4;
   // long jump in the vector table, executed by the core
   localparam int          LONG_JUMP_INSTR_CYCLES = 7;
   // global_irq_enable position in the flag register
   localparam int          GIE_BIT     = 0;
   localparam logic [7:0]  FLAGS_RST   = 8'h00;
   localparam logic [7:0]  PC_HIGH_VEC = 8'h00;
   // dispatch sequencer states
   typedef enum logic {DS_IDLE, DS_RUN} disp_state_e;
endpackage : irq_pkg

// ---- rtl/irq_core_dispatch.sv ----
// core end: 13-cycle interrupt dispatch, flag register, return
// assumes instruction boundaries and returns come as one-cycle pulses
`timescale 1ns/1ps
module irq_core_dispatch (
   input  wire logic        CORE_CLK,    // cpu clock
   input  wire logic        RST_N,       // async reset, active low
   input  wire logic        CE,          // clock enable, freezes all
   input  wire logic        INSTR_END,   // current instruction done
   input  wire logic [15:0] PC_NOW,      // return address to stack
   input  wire logic        FLAG_WR,     // software writes flags
   input  wire logic [7:0]  FLAG_WDATA,  // flag write value
   input  wire logic        RETURN_FROM_IRQ_DO,     // return completes now
   input  wire logic [7:0]  RETURN_FROM_IRQ_FLAGS,  // flags popped by return
   output logic             BUSY,        // dispatch in progress
   output logic             STACK_PUSH,  // one byte to the stack
   output logic      [7:0]  STACK_DATA,  // byte pushed
   output logic             PC_LOAD,     // load PC_VALUE now
   output logic      [15:0] PC_VALUE,    // vector table address
   output logic      [7:0]  FLAGS,       // flag register
   irq_link_if.core         link         // to the controller
);

   irq_pkg::disp_state_e state_q;
   logic [3:0]  cnt_q;      // dispatch cycle count
   logic [15:0] pc_q;       // captured return address
   logic [7:0]  flags_q;    // flag register
   logic [7:0]  vec_q;      // captured vector
   logic        push_q;
   logic [7:0]  sdata_q;
   logic        load_q;
   logic        busy_q;
   logic        ack_q;
   logic [7:0]  flags_eff;  // flags as seen at the boundary
   logic        boundary;   // instruction boundary this cycle
   logic        take;       // start dispatch

   // a completing return counts as a boundary with restored flags
   always_comb
   begin
      boundary  = INSTR_END || RETURN_FROM_IRQ_DO;
      flags_eff = RETURN_FROM_IRQ_DO ? RETURN_FROM_IRQ_FLAGS
                : (FLAG_WR ? FLAG_WDATA : flags_q);
      take      = (state_q == irq_pkg::DS_IDLE) && boundary
                  && link.irq_req
                  && flags_eff[irq_pkg::GIE_BIT];
   end

   // sequencer state and cycle count
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state_q <= irq_pkg::DS_IDLE;
         cnt_q   <= '0;
         pc_q    <= '0;
      end
      else if (CE)
      begin
         case (state_q)
            irq_pkg::DS_IDLE:
            begin
               if (take)
               begin
                  state_q <= irq_pkg::DS_RUN;
                  cnt_q   <= '0;
                  pc_q    <= PC_NOW;
               end
            end
            irq_pkg::DS_RUN:
            begin
               // thirteen counts, 0 to 12
               if (cnt_q == irq_pkg::DISP_LAST)
               begin
                  state_q <= irq_pkg::DS_IDLE;
               end
               cnt_q <= cnt_q + 4'h1;
            end
            default:
            begin
               state_q <= irq_pkg::DS_IDLE;
            end
         endcase
      end
   end

   // stack pushes: high pc, low pc, then flags
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         push_q  <= 1'b0;
         sdata_q <= '0;
      end
      else if (CE)
      begin
         push_q <= 1'b0;
         if (state_q == irq_pkg::DS_RUN)
         begin
            case (cnt_q)
               irq_pkg::STEP_PCH:
               begin
                  push_q  <= 1'b1;
                  sdata_q <= pc_q[15:8];
               end
               irq_pkg::STEP_PCL:
               begin
                  push_q  <= 1'b1;
                  sdata_q <= pc_q[7:0];
               end
               irq_pkg::STEP_FLAGS:
               begin
                  push_q  <= 1'b1;
                  sdata_q <= flags_q;
               end
               default:
               begin
                  sdata_q <= sdata_q;
               end
            endcase
         end
      end
   end

   // flag register: cleared after stacking, restored by return
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         flags_q <= irq_pkg::FLAGS_RST;
      end
      else if (CE)
      begin
         if (state_q == irq_pkg::DS_RUN && cnt_q == irq_pkg::STEP_FCLR)
         begin
            flags_q <= irq_pkg::FLAGS_RST;
         end
         else if (state_q == irq_pkg::DS_IDLE)
         begin
            flags_q <= flags_eff;
         end
      end
   end

   // acknowledge pulse and vector capture
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         ack_q <= 1'b0;
         vec_q <= '0;
      end
      else if (CE)
      begin
         ack_q <= (state_q == irq_pkg::DS_RUN)
                  && (cnt_q == irq_pkg::STEP_ACK);
         if (ack_q)
         begin
            vec_q <= link.irq_vec;
         end
      end
   end

   // busy window and final pc load
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         busy_q <= 1'b0;
         load_q <= 1'b0;
      end
      else if (CE)
      begin
         busy_q <= take || (state_q == irq_pkg::DS_RUN
                   && cnt_q != irq_pkg::DISP_LAST);
         // core then runs the 7-cycle long jump
         load_q <= (state_q == irq_pkg::DS_RUN)
                   && (cnt_q == irq_pkg::DISP_LAST);
      end
   end

   // outputs straight from flops
   assign BUSY         = busy_q;
   assign STACK_PUSH   = push_q;
   assign STACK_DATA   = sdata_q;
   assign PC_LOAD      = load_q;
   assign PC_VALUE     = {irq_pkg::PC_HIGH_VEC, vec_q};
   assign FLAGS        = flags_q;
   assign link.irq_ack = ack_q;

endmodule : irq_core_dispatch

// ---- rtl/irq_ctrl_device.sv ----
// interrupt controller: posted latches, masks, clear regs, encoder
// assumes sources pulse on CORE_CLK; core end speaks irq_link_if
//
// Function
// - request active on event, unmask, or enable
// - dispatch only at an instruction boundary
// - dispatch lasts exactly 13 cycles
// - push high pc, low pc, flags
// - flags cleared after stacking
// - pc high zero, low gets vector
// - return restores pc and flags
// - pending requests dispatched after return first
// - latency: finish plus 13 plus 7
// - clear register reads show posted bits
// - soft off: zero clears, one ignored
// - soft on: one posts, zero ignored
// - low clear register bit layout
// - mid clear register bit layout
// - high clear register bit layout
// - mask gates pending, never posting
// - every mask bit independent
// - soft enable bit 7, resets zero
// - encoder offers highest pending to core
// - lower number wins, vectors four apart
// - posted stays until taken or cleared
`timescale 1ns/1ps
module irq_ctrl_device (
   input  wire logic        CORE_CLK,   // cpu clock
   input  wire logic        RST_N,      // async reset, active low
   input  wire logic        CE,         // clock enable, freezes all
   input  wire logic [23:0] SRC_EVENT,  // source pulses, view order
   input  wire logic [7:0]  REG_ADDR,   // register address
   input  wire logic [7:0]  REG_WDATA,  // write data
   input  wire logic        REG_WR,     // write strobe
   input  wire logic        REG_RD,     // read strobe
   output logic      [7:0]  REG_RDATA,  // read data, next cycle
   output logic      [23:0] POSTED,     // posted latches
   irq_link_if.ctrl         link        // to the core end
);

   // posted latches in register view order
   logic [23:0] posted_q;
   logic [23:0] posted_d;
   // mask bits in the same order
   logic [23:0] mask_q;
   // soft interrupt control register
   logic [7:0]  soft_ctl_q;
   // read data register
   logic [7:0]  rdata_q;
   // link outputs
   logic        req_q;
   logic [7:0]  vec_q;
   // view bit of the source presented to the core
   logic [4:0]  sel_pos_q;
   // software write effects
   logic [23:0] sw_set;
   logic [23:0] sw_clr;
   // acknowledge effect
   logic [23:0] ack_clr;
   // pending vector and encoder result
   logic [23:0] pending;
   logic        enc_hit;
   logic [4:0]  enc_pos;
   logic [4:0]  enc_num;
   // write lane select per clear register
   logic [2:0]  clr_sel;
   logic        soft_en;

   assign soft_en = soft_ctl_q[irq_pkg::SOFT_EN_BIT];

   // decode which clear register is written
   always_comb
   begin
      clr_sel[0] = REG_WR && (REG_ADDR == irq_pkg::CLR_LOW_OFS);
      clr_sel[1] = REG_WR && (REG_ADDR == irq_pkg::CLR_MID_OFS);
      clr_sel[2] = REG_WR && (REG_ADDR == irq_pkg::CLR_HIGH_OFS);
   end

   // write data mapped to set and clear masks
   always_comb
   begin
      sw_set = '0;
      sw_clr = '0;
      for (int r = 0; r < 3; r++)
      begin
         if (clr_sel[r])
         begin
            // soft on: ones post, zeros ignored
            if (soft_en)
            begin
               sw_set[8*r +: 8] = REG_WDATA;
            end
            // soft off: zeros clear, ones ignored
            else
            begin
               sw_clr[8*r +: 8] = ~REG_WDATA;
            end
         end
      end
   end

   // acknowledged source loses its latch
   always_comb
   begin
      ack_clr = '0;
      if (link.irq_ack)
      begin
         ack_clr[sel_pos_q] = 1'b1;
      end
   end

   // next posted state: any set wins over any clear
   always_comb
   begin
      posted_d = ((posted_q & ~sw_clr & ~ack_clr)
                  | SRC_EVENT | sw_set) & irq_pkg::VIEW_USED;
   end

   // posted latch register
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         posted_q <= irq_pkg::POSTED_RST;
      end
      else if (CE)
      begin
         posted_q <= posted_d;
      end
   end

   // mask registers, one lane each, bits independent
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         mask_q <= '0;
      end
      else if (CE && REG_WR)
      begin
         // each write touches only its own lane
         case (REG_ADDR)
            irq_pkg::MASK_LO_OFS:  mask_q[7:0]   <= REG_WDATA;
            irq_pkg::MASK_MID_OFS: mask_q[15:8]  <= REG_WDATA;
            irq_pkg::MASK_HI_OFS:  mask_q[23:16] <= REG_WDATA;
            default:               mask_q        <= mask_q;
         endcase
      end
   end

   // soft control register, only bit 7 is kept
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         soft_ctl_q <= irq_pkg::REG_RST;
      end
      else if (CE && REG_WR && (REG_ADDR == irq_pkg::SOFT_CTL_OFS))
      begin
         // reserved bits stay zero
         soft_ctl_q <= {REG_WDATA[irq_pkg::SOFT_EN_BIT], 7'h00};
      end
   end

   // mask gates only the path to the encoder
   assign pending = posted_q & mask_q & irq_pkg::VIEW_USED;

   // priority encoder: lowest priority number wins
   always_comb
   begin
      enc_hit = 1'b0;
      enc_pos = '0;
      enc_num = '0;
      // scan from lowest precedence up so the best one lands last
      for (int i = irq_pkg::NSRC - 1; i >= 0; i--)
      begin
         if (pending[irq_pkg::PRIO_POS[i]])
         begin
            enc_hit = 1'b1;
            enc_pos = irq_pkg::PRIO_POS[i];
            enc_num = irq_pkg::PRIO_NUM[i];
         end
      end
   end

   // registered request and vector toward the core
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         req_q     <= 1'b0;
         vec_q     <= irq_pkg::REG_RST;
         sel_pos_q <= '0;
      end
      else if (CE)
      begin
         // ack cycle: hold off a stale request for one cycle
         req_q     <= enc_hit && !link.irq_ack;
         vec_q     <= {1'b0, enc_num, 2'b00};
         sel_pos_q <= enc_pos;
      end
   end

   // read mux: clear regs show posted, masks show masks
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rdata_q <= irq_pkg::REG_RST;
      end
      else if (CE && REG_RD)
      begin
         case (REG_ADDR)
            irq_pkg::CLR_LOW_OFS:  rdata_q <= posted_q[7:0];
            irq_pkg::CLR_MID_OFS:  rdata_q <= posted_q[15:8];
            irq_pkg::CLR_HIGH_OFS: rdata_q <= posted_q[23:16];
            irq_pkg::SOFT_CTL_OFS: rdata_q <= soft_ctl_q;
            irq_pkg::MASK_LO_OFS:  rdata_q <= mask_q[7:0];
            irq_pkg::MASK_MID_OFS: rdata_q <= mask_q[15:8];
            irq_pkg::MASK_HI_OFS:  rdata_q <= mask_q[23:16];
            // unmapped addresses read zero
            default:               rdata_q <= irq_pkg::REG_RST;
         endcase
      end
   end

   // outputs straight from flops
   assign REG_RDATA    = rdata_q;
   assign POSTED       = posted_q;
   assign link.irq_req = req_q;
   assign link.irq_vec = vec_q;

endmodule : irq_ctrl_device

// ---- test/irq_link_props.sv ----
// checker for the link between controller and core end
// assumes one clock, async active-low reset, CE held high
`timescale 1ns/1ps
module irq_link_props (
   input wire logic       CORE_CLK, // cpu clock
   input wire logic       RST_N,    // async reset, active low
   input wire logic       irq_req,  // pending request
   input wire logic [7:0] irq_vec,  // offered vector
   input wire logic       irq_ack   // core acknowledge
);
   // one domain: shared clock and reset
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);
   // acknowledge is a lone pulse
   chk_ack_single: assert property (irq_ack |=> !irq_ack)
      else $error("ack held over one cycle");
   // acknowledge only while a request stands
   chk_ack_has_req: assert property (irq_ack |-> irq_req)
      else $error("ack without request");
   // start edge six cycles before ack saw the request
   chk_ack_after_start: assert property (irq_ack |-> $past(irq_req, 6))
      else $error("ack not six cycles after start");
   // taken source drops its request at once
   chk_req_drop: assert property (irq_ack |=> !irq_req)
      else $error("request kept after ack");
   // vectors sit four bytes apart
   chk_vec_align: assert property (irq_req |-> irq_vec[1:0] == 2'h0)
      else $error("vector not four aligned");
   // vectors inside the table
   chk_vec_range: assert property (irq_req |-> irq_vec inside {[8'h04:8'h64]})
      else $error("vector out of table");
   // no second ack during a dispatch
   chk_ack_spacing: assert property (irq_ack |=> !irq_ack [*8])
      else $error("acks too close");
   // vector loaded into the pc is never zero
   chk_ack_vec: assert property (irq_ack |-> irq_vec != 8'h00)
      else $error("zero vector at ack");
endmodule : irq_link_props

// ---- test/tb_vectored_irq_controller.sv ----
// testbench joining controller and core end across the link
// assumes 100 MHz clock, CE high except one frozen cycle, checker beside the link
`timescale 1ns/1ps
module tb_vectored_irq_controller;
   logic        CORE_CLK = 1'b0; // cpu clock
   logic        ce = 1'b1;       // clock enable to both ends
   logic        RST_N = 1'b0;    // reset, active low
   logic [23:0] src = 24'h0;     // source pulses
   logic [7:0]  addr = 8'h0;     // register address
   logic [7:0]  wdat = 8'h0;     // write data
   logic        wr = 1'b0;       // write strobe
   logic        rd = 1'b0;       // read strobe
   logic        iend = 1'b0;     // instruction done
   logic [15:0] pc = 16'h1234;   // program point
   logic        fwr = 1'b0;      // flag write
   logic [7:0]  fdat = 8'h0;     // flag value
   logic        return_from_irq = 1'b0;     // return done
   logic [7:0]  rflg = 8'h0;     // popped flags
   logic [7:0]  rdat;            // read data
   logic [23:0] posted;          // posted latches
   logic        busy;            // dispatch running
   logic        push;            // stack write
   logic [7:0]  sdat;            // stacked byte
   logic        load;            // pc load
   logic [15:0] pcv;             // pc load value
   logic [7:0]  flags;           // flag register
   logic [15:0] exp_q [$];       // expected results, oldest first
   logic        rd_pend = 1'b0;  // read answer due
   int          bcnt = 0;        // busy cycles seen
   int          n_mismatch = 0;  // mismatches
   int          check_count = 0; // comparisons
   int          seed;            // random seed
   int          rv;              // raw random
   logic [7:0]  r1;              // first random byte
   logic [7:0]  r2;              // second random byte
   irq_link_if link ();          // the link under test
   // free-running clock
   always #5 CORE_CLK = ~CORE_CLK;
   irq_ctrl_device u_irq_ctrl_device (
      .CORE_CLK (CORE_CLK), .RST_N (RST_N), .CE (ce),
      .SRC_EVENT (src), .REG_ADDR (addr), .REG_WDATA (wdat),
      .REG_WR (wr), .REG_RD (rd), .REG_RDATA (rdat),
      .POSTED (posted), .link (link));
   irq_core_dispatch u_irq_core_dispatch (
      .CORE_CLK (CORE_CLK), .RST_N (RST_N), .CE (ce),
      .INSTR_END (iend), .PC_NOW (pc), .FLAG_WR (fwr),
      .FLAG_WDATA (fdat), .RETURN_FROM_IRQ_DO (return_from_irq), .RETURN_FROM_IRQ_FLAGS (rflg),
      .BUSY (busy), .STACK_PUSH (push), .STACK_DATA (sdat),
      .PC_LOAD (load), .PC_VALUE (pcv), .FLAGS (flags),
      .link (link));
   irq_link_props u_irq_link_props (
      .CORE_CLK (CORE_CLK), .RST_N (RST_N), .irq_req (link.irq_req),
      .irq_vec (link.irq_vec), .irq_ack (link.irq_ack));
   // verdict and end of run
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   // one comparison
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // compare a result against the oldest note
   task automatic take(input logic [15:0] got);
      if (exp_q.size() == 0)
         chk(got, 16'hFFFF);
      else
         chk(got, exp_q.pop_front());
   endtask : take
   // register write, one cycle strobe
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge CORE_CLK);
      addr = a;
      wdat = d;
      wr = 1'b1;
      @(negedge CORE_CLK);
      wr = 1'b0;
   endtask : wr_reg
   // register read, answer noted for the monitor
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(negedge CORE_CLK);
      addr = a;
      rd = 1'b1;
      exp_q.push_back({8'h00, e});
      @(negedge CORE_CLK);
      rd = 1'b0;
   endtask : rd_reg
   // software flag write setting the global enable
   task automatic set_gie();
      @(negedge CORE_CLK);
      fdat = 8'h01;
      fwr = 1'b1;
      @(negedge CORE_CLK);
      fwr = 1'b0;
   endtask : set_gie
   // instruction end or return, one cycle
   task automatic pulse_end(input logic r);
      @(negedge CORE_CLK);
      if (r)
         return_from_irq = 1'b1;
      else
         iend = 1'b1;
      @(negedge CORE_CLK);
      return_from_irq = 1'b0;
      iend = 1'b0;
   endtask : pulse_end
   // boundary with dispatch expected: stack bytes then pc load
   task automatic boundary(input logic r, input logic [7:0] fl,
                           input logic [7:0] vec);
      int i;
      exp_q.push_back({8'h00, pc[15:8]});
      exp_q.push_back({8'h00, pc[7:0]});
      exp_q.push_back({8'h00, fl});
      exp_q.push_back({8'h00, vec});
      pulse_end(r);
      for (i = 0; i < 40 && load !== 1'b1; i++)
         @(negedge CORE_CLK);
      if (i == 40)
         chk(16'hDEAD, 16'h0000);
      // load stands 13 falling edges after the boundary pulse ends
      chk(i[15:0], 16'h000D);
      @(negedge CORE_CLK);
   endtask : boundary
   // monitor: results in order of appearance
   always @(posedge CORE_CLK)
   begin
      if (rd_pend)
         take({8'h00, rdat});
      if (push === 1'b1)
         take({8'h00, sdat});
      if (load === 1'b1)
      begin
         take(pcv);
         chk(bcnt[15:0], 16'h000D);
         bcnt = 0;
      end
      if (busy === 1'b1)
         bcnt++;
      rd_pend = rd;
   end
   // hang guard
   initial
   begin
      #50us;
      n_mismatch++;
      wrap_up();
   end
   // main sequence
   initial
   begin
      seed = 20204;
      repeat (2) @(negedge CORE_CLK);
      RST_N = 1'b1;
      rd_reg(8'hDA, 8'h00);
      rd_reg(8'hDB, 8'h00);
      rd_reg(8'hDC, 8'h00);
      rd_reg(8'hDE, 8'h00);
      rd_reg(8'hD0, 8'h00);
      $display("test reset done");
      rv = $random(seed);
      r1 = rv[7:0];
      rv = $random(seed);
      r2 = rv[7:0];
      // frozen clock enable drops a source pulse
      ce = 1'b0;
      src = 24'h000080;
      @(negedge CORE_CLK);
      ce = 1'b1;
      src = 24'h000000;
      @(negedge CORE_CLK);
      chk(posted[15:0], 16'h0000);
      wr_reg(8'hDE, 8'hFF);
      rd_reg(8'hDE, 8'h80);
      wr_reg(8'hDB, r1);
      wr_reg(8'hDB, 8'h00);
      rd_reg(8'hDB, r1);
      wr_reg(8'hDC, 8'hFF);
      chk({8'h00, posted[23:16]}, 16'h007F);
      rd_reg(8'hDC, 8'h7F);
      wr_reg(8'hDE, 8'h00);
      wr_reg(8'hDB, r2);
      rd_reg(8'hDB, r1 & r2);
      wr_reg(8'hDB, 8'h00);
      wr_reg(8'hDC, 8'h00);
      rd_reg(8'hDC, 8'h00);
      wr_reg(8'hDE, 8'h80);
      @(negedge CORE_CLK);
      RST_N = 1'b0;
      repeat (2) @(negedge CORE_CLK);
      RST_N = 1'b1;
      rd_reg(8'hDE, 8'h00);
      $display("test soft done");
      wr_reg(irq_pkg::MASK_HI_OFS, 8'h5A);
      wr_reg(irq_pkg::MASK_MID_OFS, 8'hA5);
      rd_reg(irq_pkg::MASK_HI_OFS, 8'h5A);
      rd_reg(irq_pkg::MASK_MID_OFS, 8'hA5);
      rd_reg(irq_pkg::MASK_LO_OFS, 8'h00);
      wr_reg(irq_pkg::MASK_LO_OFS, 8'hFF);
      set_gie();
      @(negedge CORE_CLK);
      src = 24'h000041;
      @(negedge CORE_CLK);
      src = 24'h000000;
      chk(posted[15:0], 16'h0041);
      rd_reg(8'hDA, 8'h41);
      boundary(1'b0, 8'h01, 8'h04);
      chk({8'h00, flags}, 16'h0000);
      rflg = 8'h01;
      boundary(1'b1, 8'h01, 8'h64);
      rd_reg(8'hDA, 8'h00);
      $display("test dispatch done");
      wr_reg(irq_pkg::MASK_LO_OFS, 8'hFD);
      set_gie();
      @(negedge CORE_CLK);
      src = 24'h000002;
      @(negedge CORE_CLK);
      src = 24'h000000;
      pulse_end(1'b0);
      repeat (16) @(negedge CORE_CLK);
      rd_reg(8'hDA, 8'h02);
      @(negedge CORE_CLK);
      fdat = 8'h00;
      fwr = 1'b1;
      @(negedge CORE_CLK);
      fwr = 1'b0;
      wr_reg(irq_pkg::MASK_LO_OFS, 8'hFF);
      pulse_end(1'b0);
      repeat (16) @(negedge CORE_CLK);
      set_gie();
      boundary(1'b0, 8'h01, 8'h08);
      $display("test mask done");
      if (exp_q.size() != 0)
         chk(16'(exp_q.size()), 16'h0000);
      wrap_up();
   end
endmodule : tb_vectored_irq_controller
